// ---- shared/supervisor_pkg.sv ----
package supervisor_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS       = 5000;
  // reset hold period and watchdog period, in microseconds
  localparam int unsigned RESET_HOLD_US       = 150000;
  localparam int unsigned WATCHDOG_PERIOD_US  = 1600000;
  localparam int unsigned RESET_HOLD_CYCLES   = (RESET_HOLD_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned WATCHDOG_CYCLES     = (WATCHDOG_PERIOD_US / 1000) * (1000000 / (CLK_PERIOD_PS / 1000));
  // shortest watchdog pulse that must register, in ns
  localparam int unsigned MIN_PULSE_NS        = 150;
  localparam int unsigned MIN_PULSE_CYCLES    = (MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W               = 32;
  localparam logic        SYNC_RESET_VALUE    = 1'b0;
  localparam logic        MANUAL_RESET_VALUE  = 1'b1;

  // synchronised input bundle
  typedef struct packed {
    logic undervolt;
    logic manual_n;
    logic kick;
  } sync_in_s;

endpackage

// ---- verilog/input_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser, one lane per bit
module input_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // --------------------------------------------------------------
  // synchroniser lanes
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic meta_q;
      logic stable_q;
      // first flop is only ever read by the second
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          meta_q   <= RESET_VALUE[g];
          stable_q <= RESET_VALUE[g];
        end else begin
          meta_q   <= async_in[g];
          stable_q <= meta_q;
        end
      end
      assign sync_out[g] = stable_q;
    end
  endgenerate

endmodule // input_sync

`default_nettype wire

// ---- verilog/supervisor_watchdog_reset.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - reset_out_n low on undervoltage, manual reset low, or watchdog expiry
// - reset held for the full hold period after every cause clears
// - active-high output is the exact inverse of the active-low output
// - active-high output stays high for hold period, then falls
// - reset held while manual input low and hold period after release
// - processor toggles watchdog input in time; otherwise expiry forces reset
// - watchdog counter clears on reset, manual reset, or any input edge
// - manual input has no pullup; only its sync lane resets high, while rstn is low
// - watchdog frozen during reset, restarts from zero on release
// - short watchdog pulses count as toggles; no level filtering
module supervisor_watchdog_reset
  import supervisor_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES     = RESET_HOLD_CYCLES,
  parameter int unsigned WATCHDOG_LIMIT  = WATCHDOG_CYCLES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // monitored conditions
  input  wire logic undervolt_in,
  input  wire logic manual_reset_in_n,
  input  wire logic watchdog_toggle_in,
  // reset outputs
  output logic      reset_out_n,
  output logic      reset_out,
  // status
  output logic      watchdog_expired
);

  // --------------------------------------------------------------
  // input synchronisation
  // --------------------------------------------------------------
  sync_in_s raw_in;
  sync_in_s sync_in;

  // manual lane resets high so an idle input never looks asserted
  assign raw_in = '{undervolt: undervolt_in, manual_n: manual_reset_in_n, kick: watchdog_toggle_in};

  input_sync #(
    .WIDTH       (3),
    .RESET_VALUE ({SYNC_RESET_VALUE, MANUAL_RESET_VALUE, SYNC_RESET_VALUE})
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef enum logic [1:0] {ST_ASSERT, ST_HOLD, ST_RUN} state_e;

  state_e           state_q, state_d;
  logic [CNT_W-1:0] hold_cnt_q, hold_cnt_d;
  logic [CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic             kick_prev_q;
  logic             wd_exp_q, wd_exp_d;
  logic             rst_q, rst_d;

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  wire manual_req  = !sync_in.manual_n;
  wire kick_edge   = sync_in.kick ^ kick_prev_q;
  wire wd_timeout  = (wd_cnt_q >= CNT_W'(WATCHDOG_LIMIT - 1)) && !kick_edge;
  // any live cause; expiry latches until its own hold finishes
  wire cause       = sync_in.undervolt || manual_req || wd_exp_q;
  wire hold_done   = (hold_cnt_q >= CNT_W'(HOLD_CYCLES - 1));

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    hold_cnt_d = hold_cnt_q;
    wd_cnt_d   = wd_cnt_q;
    wd_exp_d   = wd_exp_q;
    case (state_q)
      ST_ASSERT: begin
        hold_cnt_d = '0;
        wd_cnt_d   = '0;
        if (!(sync_in.undervolt || manual_req)) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        wd_cnt_d = '0;
        if (sync_in.undervolt || manual_req) begin
          state_d    = ST_ASSERT;
          hold_cnt_d = '0;
        end else if (hold_done) begin
          state_d  = ST_RUN;
          wd_exp_d = 1'b0;
        end else begin
          hold_cnt_d = hold_cnt_q + CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (sync_in.undervolt || manual_req) begin
          state_d  = ST_ASSERT;
          wd_cnt_d = '0;
        end else if (wd_timeout) begin
          state_d    = ST_HOLD;
          wd_exp_d   = 1'b1;
          hold_cnt_d = '0;
          wd_cnt_d   = '0;
        end else if (kick_edge) begin
          wd_cnt_d = '0;
        end else begin
          wd_cnt_d = wd_cnt_q + CNT_W'(1);
        end
      end
      default: state_d = ST_ASSERT;
    endcase
    rst_d = (state_d != ST_RUN);
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // power-up lands in assert so reset is low from the first instant
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q    <= ST_ASSERT;
      hold_cnt_q <= '0;
      wd_cnt_q   <= '0;
      kick_prev_q <= SYNC_RESET_VALUE;
      wd_exp_q   <= 1'b0;
      rst_q      <= 1'b1;
    end else begin
      state_q    <= state_d;
      hold_cnt_q <= hold_cnt_d;
      wd_cnt_q   <= wd_cnt_d;
      kick_prev_q <= sync_in.kick;
      wd_exp_q   <= wd_exp_d;
      rst_q      <= rst_d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign reset_out_n      = !rst_q;
  assign reset_out        = rst_q;
  assign watchdog_expired = wd_exp_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_cause_asserts;
    @(posedge clk_sys) disable iff (!rstn)
      (sync_in.undervolt || manual_req) |=> !reset_out_n;
  endproperty
  a_cause_asserts: assert property (p_cause_asserts) else $error("cause did not assert reset");

  property p_hold_min;
    @(posedge clk_sys) disable iff (!rstn)
      $rose(state_q == ST_HOLD) |-> (hold_cnt_q == '0);
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("hold count not restarted");

  property p_inverse;
    @(posedge clk_sys) disable iff (!rstn)
      reset_out == !reset_out_n;
  endproperty
  a_inverse: assert property (p_inverse) else $error("outputs not inverse");

  property p_release_after_hold;
    @(posedge clk_sys) disable iff (!rstn)
      $fell(reset_out) |-> $past(state_q) == ST_HOLD && $past(hold_done);
  endproperty
  a_release_after_hold: assert property (p_release_after_hold) else $error("early release");

  property p_manual_held;
    @(posedge clk_sys) disable iff (!rstn)
      manual_req [*2] |-> reset_out;
  endproperty
  a_manual_held: assert property (p_manual_held) else $error("reset released with manual low");

  property p_wd_expiry;
    @(posedge clk_sys) disable iff (!rstn)
      (state_q == ST_RUN && wd_timeout && !cause) |=> (reset_out && wd_exp_q);
  endproperty
  a_wd_expiry: assert property (p_wd_expiry) else $error("watchdog expiry missed");

  property p_wd_clear_edge;
    @(posedge clk_sys) disable iff (!rstn)
      (kick_edge || rst_q) |=> (wd_cnt_q == '0);
  endproperty
  a_wd_clear_edge: assert property (p_wd_clear_edge) else $error("watchdog counter not cleared");

  property p_wd_frozen;
    @(posedge clk_sys) disable iff (!rstn)
      (state_q != ST_RUN) |-> (wd_cnt_q == '0 || $past(state_q) == ST_RUN);
  endproperty
  a_wd_frozen: assert property (p_wd_frozen) else $error("watchdog counted in reset");

  property p_idle_manual;
    @(posedge clk_sys) disable iff (!rstn)
      (state_q == ST_RUN && !sync_in.undervolt && sync_in.manual_n && !wd_timeout) |=> !reset_out;
  endproperty
  a_idle_manual: assert property (p_idle_manual) else $error("spurious reset");

  // an unfinished hold must never hand over to the running state
  property p_hold_full;
    @(posedge clk_sys) disable iff (!rstn)
      (state_q == ST_HOLD && !hold_done) |=> (state_q != ST_RUN);
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("hold cut short");

  // the expiry flag only rises from a real timeout
  property p_no_false_expiry;
    @(posedge clk_sys) disable iff (!rstn)
      (state_q == ST_RUN && !wd_timeout) |=> !watchdog_expired;
  endproperty
  a_no_false_expiry: assert property (p_no_false_expiry) else $error("expiry without timeout");

  // counting restarts from zero once reset lets go
  property p_resume_zero;
    @(posedge clk_sys) disable iff (!rstn)
      $fell(rst_q) |-> (wd_cnt_q == '0);
  endproperty
  a_resume_zero: assert property (p_resume_zero) else $error("watchdog not restarted from zero");

endmodule // supervisor_watchdog_reset

`default_nettype wire

// ---- bench/uproc_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// processor side: takes the reset, kicks the watchdog
// ----------------------------------------------------------------
module uproc_model (
  // clock
  input  wire logic       clk_sys,
  // reset from the supervisor
  input  wire logic       reset_out_n,
  // kick half period in cycles, zero means a stalled processor
  input  wire logic [7:0] kick_half,
  // kick line
  output var  logic       watchdog_toggle_in
);
  logic [7:0] cnt_q   = 8'h00;
  logic       level_q = 1'b0;

  // one driver for the kick line
  assign watchdog_toggle_in = level_q;

  // a stalled core keeps its last level, which is what the watchdog must catch
  always @(negedge clk_sys) begin
    if (!reset_out_n || kick_half == 8'h00) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= kick_half - 8'h01) begin
      cnt_q              <= 8'h00;
      level_q <= ~level_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // uproc_model

`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import supervisor_pkg::*;
  localparam int HOLD = 20;
  localparam int WD   = 50;

  typedef struct packed {
    logic       uv;
    logic       man_n;
    logic [7:0] kick;
    logic [7:0] wait_c;
    logic       rst_n;
    logic       wd;
  } row_s;

  logic       clk_sys = 1'b0;
  logic       rstn    = 1'b0;
  logic       uv      = 1'b0;
  logic       man_n   = 1'b1;
  logic [7:0] kick    = 8'h00;
  logic       wd_line;
  logic       reset_out_n;
  logic       reset_out;
  logic       watchdog_expired;
  int         failures = 0;
  int         cmp_count = 0;
  int         n;

  // 200 MHz
  always #2.5 clk_sys = ~clk_sys;

  supervisor_watchdog_reset #(.HOLD_CYCLES(HOLD), .WATCHDOG_LIMIT(WD)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .undervolt_in(uv), .manual_reset_in_n(man_n),
    .watchdog_toggle_in(wd_line), .reset_out_n(reset_out_n), .reset_out(reset_out),
    .watchdog_expired(watchdog_expired));

  uproc_model u_cpu (.clk_sys(clk_sys), .reset_out_n(reset_out_n), .kick_half(kick),
    .watchdog_toggle_in(wd_line));

  // ordinary cases: inputs, cycles to wait, expected outputs
  row_s rows [6] = '{
    '{1'b0, 1'b1, 8'h0A, 8'h64, 1'b1, 1'b0},
    '{1'b1, 1'b1, 8'h0A, 8'h0A, 1'b0, 1'b0},
    '{1'b0, 1'b0, 8'h0A, 8'h28, 1'b0, 1'b0},
    '{1'b0, 1'b1, 8'h0A, 8'h28, 1'b1, 1'b0},
    '{1'b0, 1'b1, 8'h00, 8'h3A, 1'b0, 1'b1},
    '{1'b0, 1'b1, 8'h02, 8'hFA, 1'b1, 1'b0}};

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // cycles until reset_out_n reaches a level, bounded so a stuck output cannot hang us
  task automatic wait_level(input logic lvl, output int cnt);
    cnt = 0;
    while (reset_out_n !== lvl && cnt < 200) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys);
    check("por_n", {7'h00, reset_out_n}, 8'h00);
    rstn = 1'b1;
    foreach (rows[i]) begin
      uv   = rows[i].uv;
      man_n = rows[i].man_n;
      kick = rows[i].kick;
      repeat (rows[i].wait_c) @(negedge clk_sys);
      check("reset_out_n", {7'h00, reset_out_n}, {7'h00, rows[i].rst_n});
      check("reset_out", {7'h00, reset_out}, {7'h00, ~rows[i].rst_n});
      check("wd_expired", {7'h00, watchdog_expired}, {7'h00, rows[i].wd});
      $display("row %0d done", i);
    end
    // short manual pulse, then measure the hold
    man_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("manual_asserted", {7'h00, reset_out}, 8'h01);
    man_n = 1'b1;
    wait_level(1'b1, n);
    check("hold_min", 8'(n >= HOLD + 1), 8'h01);
    check("hold_max", 8'(n <= HOLD + 5), 8'h01);
    $display("manual hold test done");
    // stalled core: expiry one period after release, then a full hold
    kick = 8'h00;
    wait_level(1'b0, n);
    check("wd_expiry_min", 8'(n >= WD), 8'h01);
    check("wd_expiry_max", 8'(n <= WD + 3), 8'h01);
    check("wd_flag_set", {7'h00, watchdog_expired}, 8'h01);
    check("wd_out_high", {7'h00, reset_out}, 8'h01);
    wait_level(1'b1, n);
    check("wd_hold", 8'(n >= HOLD && n <= HOLD + 3), 8'h01);
    check("wd_flag_clear", {7'h00, watchdog_expired}, 8'h00);
    check("wd_out_low", {7'h00, reset_out}, 8'h00);
    $display("watchdog expiry test done");
    // second power-on reset in mid-run
    rstn = 1'b0;
    @(negedge clk_sys);
    check("por2_n", {7'h00, reset_out_n}, 8'h00);
    check("por2_wd", {7'h00, watchdog_expired}, 8'h00);
    rstn = 1'b1;
    wait_level(1'b1, n);
    check("por_hold", 8'(n >= HOLD + 1 && n <= HOLD + 6), 8'h01);
    $display("power-on test done");
    report_and_stop();
  end

  // hang guard, several times the expected run
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
